// >>> shared/fpc_map.svh
// Register map, field positions and reset values of the flash prefetch cache
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE_01: Program cycle invalidates lines per coherency select
// RULE_02: Data line count sets data lines, zero disables
// RULE_03: Changing data line count invalidates every line
// RULE_04: Prefetch region field enables prefetch per region
// RULE_05: Flash access waits set states; resets seven
// RULE_06: Clear, set, invert aliases at plus 4/8/C
// RULE_07: Unimplemented control bits hold no function
// RULE_08: Unimplemented bits read zero; counters unreset
// RULE_09: Alias writes touch only bits written one
////////////////////////////////////////////////////////////////////////////////
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH

`define FPC_ADDR_W        16
`define FPC_IDX_W         4
`define FPC_OFF_CTRL      16'h4000
`define FPC_OFF_ACC       16'h4010
`define FPC_OFF_TAG       16'h4020
`define FPC_OFF_MSK       16'h4030
`define FPC_OFF_W0        16'h4040
`define FPC_OFF_W1        16'h4050
`define FPC_OFF_W2        16'h4060
`define FPC_OFF_W3        16'h4070
`define FPC_OFF_LRU       16'h4080
`define FPC_OFF_HIT       16'h4090
`define FPC_OFF_MIS       16'h40A0
`define FPC_OFF_ABT       16'h40C0

`define FPC_OP_WR         2'h0
`define FPC_OP_CLR        2'h1
`define FPC_OP_SET        2'h2
`define FPC_OP_INV        2'h3

`define FPC_CTRL_MASK     32'h0001_0337
`define FPC_CTRL_RST      32'h0000_0007
`define FPC_CTRL_COH      16
`define FPC_ACC_MASK      32'h8000_000F
`define FPC_ACC_WEN       31
`define FPC_TAG_MEM_MASK  32'h80FF_FFF0
`define FPC_TAG_VALID     3
`define FPC_TAG_LOCK      2
`define FPC_TAG_KIND      1
`define FPC_MSK_MASK      32'h0000_FFE0
`define FPC_LRU_MASK      32'h01FF_FFFF

`define FPC_BOOT_ADDR_BIT 29
`define FPC_DATA_LINES    4
`define FPC_LINE_BYTES    32'h0000_0010

`endif

// >>> shared/fpc_pkg.sv
// Types shared by the flash prefetch cache modules
`include "fpc_map.svh"
package fpc_pkg;

  typedef logic [`FPC_IDX_W-1:0] fpc_idx_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_PREF = 3'b100
  } fpc_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        is_data;
    logic        cacheable;
  } fpc_fetch_t;

  typedef struct packed {
    logic [31:0] wdata;
    logic [3:0]  word_we;
    logic        msk_we;
    logic        tag_we;
    fpc_idx_t    idx;
  } fpc_sw_t;

  typedef struct packed {
    logic         we;
    fpc_idx_t     idx;
    logic         kind;
    logic [31:0]  tag;
    logic [127:0] line;
  } fpc_fill_t;

endpackage : fpc_pkg

// >>> hdl/fpc_wait_timer.sv
// Flash access timer counting programmed wait states
`timescale 1ns/1ns
module fpc_wait_timer #(
  parameter int WS_W = 3
) (
  // Clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rst_n_i,
  // Access control
  input  wire logic            start_i,
  input  wire logic            abort_i,
  input  wire logic [WS_W-1:0] wait_i,
  // Status
  output logic                 busy_o,
  output logic                 done_o
);
  if (WS_W < 1) $error("fpc_wait_timer: WS_W must be at least 1");

  logic [WS_W-1:0] cnt_r;
  logic [WS_W:0]   lat_r;
  logic [WS_W:0]   ws_l_r;

  // Access lasts wait states plus one base cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cnt_r  <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        busy_o <= 1'b1;
        cnt_r  <= wait_i; // RULE_05
      end
      else if (busy_o & abort_i)
        busy_o <= 1'b0;
      else if (busy_o & (cnt_r == '0))
      begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
      else if (busy_o)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    lat_r  <= start_i ? '0 : lat_r + 1'b1;
    ws_l_r <= start_i ? {1'b0, wait_i} : ws_l_r;
  end

  property p_ws_latency;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    done_o |-> (lat_r == ws_l_r + 1'b1);
  endproperty
  a_ws_latency: assert property (p_ws_latency) // RULE_05
    else $error("flash access length differs from wait states");

endmodule : fpc_wait_timer

// >>> hdl/fpc_line_store.sv
// Cache line array: flags, tags, masks and line words
`timescale 1ns/1ns
`include "fpc_map.svh"
module fpc_line_store #(
  parameter int NUM_LINES = 16
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Invalidation
  input  wire logic             inv_all_i,
  input  wire logic             inv_unlocked_i,
  // Lookup
  input  fpc_pkg::fpc_fetch_t   lk_i,
  input  wire logic [2:0]       data_lines_i,
  output logic                  hit_o,
  output logic [31:0]           hit_word_o,
  // Writes
  input  fpc_pkg::fpc_sw_t      sw_i,
  input  fpc_pkg::fpc_fill_t    fill_i,
  // Software view
  output logic [31:0]           rd_tag_o,
  output logic [31:0]           rd_msk_o,
  output logic [127:0]          rd_line_o,
  output logic [NUM_LINES-1:0]  valid_o,
  output logic [NUM_LINES-1:0]  lock_o
);
  if (NUM_LINES <= `FPC_DATA_LINES || NUM_LINES > (1 << `FPC_IDX_W))
    $error("fpc_line_store: NUM_LINES out of range");

  logic [NUM_LINES-1:0] kind_r;
  logic [NUM_LINES-1:0] hit_vec;
  logic [31:0]          tag_arr  [NUM_LINES];
  logic [31:0]          msk_arr  [NUM_LINES];
  logic [127:0]         line_arr [NUM_LINES];

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < NUM_LINES; i++)
  begin : g_line
    localparam fpc_pkg::fpc_idx_t LIDX = fpc_pkg::fpc_idx_t'(i);
    logic [31:0]  tag_q;
    logic [31:0]  msk_q;
    logic [127:0] line_q;
    wire logic    sw_sel   = (sw_i.idx == LIDX);
    wire logic    fill_sel = fill_i.we & (fill_i.idx == LIDX);
    wire logic    kind_ok  = lk_i.is_data ?
                             (!kind_r[i] & (LIDX < {1'b0, data_lines_i})) : kind_r[i]; // RULE_02
    wire logic    tag_eq   = (lk_i.addr[`FPC_BOOT_ADDR_BIT] == tag_q[31]) &
                             (((lk_i.addr[23:4] ^ tag_q[23:4]) & ~msk_q[23:4]) == '0);

    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
      begin
        valid_o[i] <= 1'b0;
        lock_o[i]  <= 1'b0;
        kind_r[i]  <= 1'b1;
      end
      else
      begin
        if (sw_i.tag_we & sw_sel)
        begin
          valid_o[i] <= sw_i.wdata[`FPC_TAG_VALID];
          lock_o[i]  <= sw_i.wdata[`FPC_TAG_LOCK];
          kind_r[i]  <= sw_i.wdata[`FPC_TAG_KIND];
        end
        else if (fill_sel)
        begin
          valid_o[i] <= 1'b1;
          lock_o[i]  <= 1'b0;
          kind_r[i]  <= fill_i.kind;
        end
        // Invalidation wins over a write in the same cycle
        if (inv_all_i | (inv_unlocked_i & (!lock_o[i] | !kind_r[i]))) // RULE_01 RULE_03
          valid_o[i] <= 1'b0;
      end
    end

    // Contents stay unreset: only flags carry meaning after reset
    always_ff @(posedge clk_sys_i)
    begin
      if (sw_i.tag_we & sw_sel)
        tag_q <= sw_i.wdata & `FPC_TAG_MEM_MASK;
      else if (fill_sel)
        tag_q <= fill_i.tag & `FPC_TAG_MEM_MASK;
      // Hardware fills compare every tag bit; an unwritten mask would poison the lookup
      if (sw_i.msk_we & sw_sel)
        msk_q <= sw_i.wdata & `FPC_MSK_MASK;
      else if (fill_sel)
        msk_q <= '0;
      if (fill_sel)
        line_q <= fill_i.line;
      else if (sw_sel)
        for (int k = 0; k < 4; k++)
          if (sw_i.word_we[k])
            line_q[32*k +: 32] <= sw_i.wdata;
    end

    assign tag_arr[i]  = tag_q;
    assign msk_arr[i]  = msk_q;
    assign line_arr[i] = line_q;
    assign hit_vec[i]  = valid_o[i] & kind_ok & tag_eq;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    hit_word_o = '0;
    for (int i = 0; i < NUM_LINES; i++)
      if (hit_vec[i])
        hit_word_o = hit_word_o | line_arr[i][{lk_i.addr[3:2], 5'h00} +: 32];
  end

  wire logic idx_ok = (int'(sw_i.idx) < NUM_LINES);
  assign hit_o     = |hit_vec;
  assign rd_tag_o  = idx_ok ? (tag_arr[sw_i.idx] | {28'h0000000, valid_o[sw_i.idx],
                     lock_o[sw_i.idx], kind_r[sw_i.idx], 1'b0}) : '0; // RULE_08
  assign rd_msk_o  = idx_ok ? msk_arr[sw_i.idx] : '0;
  assign rd_line_o = idx_ok ? line_arr[sw_i.idx] : '0;

  property p_inv_all;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    inv_all_i |=> (valid_o == '0);
  endproperty
  a_inv_all: assert property (p_inv_all) // RULE_01
    else $error("line stayed valid after full invalidation");

  property p_keep_locked;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (inv_unlocked_i & !inv_all_i & !sw_i.tag_we & !fill_i.we) |=>
      (valid_o == ($past(valid_o) & $past(lock_o) & $past(kind_r)));
  endproperty
  a_keep_locked: assert property (p_keep_locked) // RULE_01
    else $error("partial invalidation touched the wrong lines");

  property p_data_gate;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (hit_o & lk_i.is_data) |-> (data_lines_i != 3'h0);
  endproperty
  a_data_gate: assert property (p_data_gate) // RULE_02
    else $error("data hit while data caching disabled");

endmodule : fpc_line_store

// >>> hdl/fpc_top.sv
// Flash prefetch cache control: register port, fetch path and flash access
`timescale 1ns/1ns
`include "fpc_map.svh"
module fpc_top #(
  parameter int NUM_LINES = 16
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  // Register port
  input  wire logic [`FPC_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic [31:0]                  reg_rdata_o,
  // Core fetch path
  input  wire logic                    fetch_req_i,
  input  fpc_pkg::fpc_fetch_t          fetch_i,
  output logic                         fetch_ack_o,
  output logic [31:0]                  fetch_rdata_o,
  // Flash array
  output logic                         flash_req_o,
  output logic [31:0]                  flash_addr_o,
  input  wire logic [127:0]            flash_line_i,
  input  wire logic                    flash_prog_cycle_i
);
  localparam int ILINES = NUM_LINES - `FPC_DATA_LINES;
  if (NUM_LINES <= `FPC_DATA_LINES || NUM_LINES > (1 << `FPC_IDX_W))
    $error("fpc_top: NUM_LINES out of range");

  logic [31:0]            ctrl_r;
  logic [31:0]            acc_r;
  logic [31:0]            hit_cnt_r;
  logic [31:0]            mis_cnt_r;
  logic [31:0]            abt_cnt_r;
  logic [1:0]             d_ptr_r;
  fpc_pkg::fpc_idx_t      i_ptr_r;
  fpc_pkg::fpc_state_t    state_r;
  fpc_pkg::fpc_state_t    state_nxt;
  fpc_pkg::fpc_fetch_t    req_r;
  logic                   pref_pend_r;
  logic [31:0]            pref_addr_r;
  logic [31:0]            flash_addr_r;
  logic                   ack_r;
  logic [31:0]            fdata_r;
  logic [31:0]            rdata_r;
  logic                   hit;
  logic [31:0]            hit_word;
  logic [31:0]            rd_tag;
  logic [31:0]            rd_msk;
  logic [127:0]           rd_line;
  logic [NUM_LINES-1:0]   valid_vec;
  logic [NUM_LINES-1:0]   lock_vec;
  logic                   t_busy;
  logic                   t_done;
  fpc_pkg::fpc_sw_t       sw;
  fpc_pkg::fpc_fill_t     fill;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire logic [`FPC_ADDR_W-1:0] base = {reg_addr_i[`FPC_ADDR_W-1:4], 4'h0};
  wire logic [1:0] op      = reg_addr_i[3:2];
  wire logic       aligned = (reg_addr_i[1:0] == 2'h0);
  wire logic       plain   = aligned & (op == `FPC_OP_WR);
  wire logic sel_ctrl = aligned & (base == `FPC_OFF_CTRL); // RULE_06
  wire logic sel_acc  = aligned & (base == `FPC_OFF_ACC);  // RULE_06
  wire logic sel_tag  = aligned & (base == `FPC_OFF_TAG);  // RULE_06
  wire logic sel_msk  = aligned & (base == `FPC_OFF_MSK);  // RULE_06
  wire logic sel_w0   = plain & (base == `FPC_OFF_W0);
  wire logic sel_w1   = plain & (base == `FPC_OFF_W1);
  wire logic sel_w2   = plain & (base == `FPC_OFF_W2);
  wire logic sel_w3   = plain & (base == `FPC_OFF_W3);
  wire logic sel_lru  = plain & (base == `FPC_OFF_LRU);
  wire logic sel_hit  = plain & (base == `FPC_OFF_HIT);
  wire logic sel_mis  = plain & (base == `FPC_OFF_MIS);
  wire logic sel_abt  = plain & (base == `FPC_OFF_ABT);
  wire logic mapped   = (plain & (sel_ctrl | sel_acc | sel_tag | sel_msk)) | sel_w0 |
                        sel_w1 | sel_w2 | sel_w3 | sel_lru | sel_hit | sel_mis | sel_abt;

  // Alias writes modify the present value of the addressed register
  wire logic [31:0] cur = sel_ctrl ? ctrl_r : sel_acc ? acc_r :
                          sel_tag ? rd_tag : sel_msk ? rd_msk : 32'h0000_0000;
  wire logic [31:0] newv =
      (op == `FPC_OP_CLR) ? (cur & ~reg_wdata_i) :  // RULE_09
      (op == `FPC_OP_SET) ? (cur | reg_wdata_i) :   // RULE_09
      (op == `FPC_OP_INV) ? (cur ^ reg_wdata_i) :   // RULE_09
      reg_wdata_i;

  wire logic        ctrl_wr  = reg_wr_i & sel_ctrl;
  wire logic [31:0] ctrl_nxt = newv & `FPC_CTRL_MASK; // RULE_07
  wire logic        data_line_count_chg = ctrl_wr & (ctrl_nxt[9:8] != ctrl_r[9:8]);
  wire logic        coh      = ctrl_r[`FPC_CTRL_COH];
  wire logic        inv_all  = data_line_count_chg | (flash_prog_cycle_i & coh); // RULE_03 RULE_01
  wire logic        inv_unl  = flash_prog_cycle_i & !coh; // RULE_01
  wire logic        line_wen = acc_r[`FPC_ACC_WEN];

  wire logic [31:0] lru_val = {16'h0000, 8'h00, 2'h0, i_ptr_r, d_ptr_r} & `FPC_LRU_MASK;
  wire logic [31:0] rd_val  = // RULE_08
      (plain & sel_ctrl) ? ctrl_r : (plain & sel_acc) ? acc_r :
      (plain & sel_tag) ? rd_tag : (plain & sel_msk) ? rd_msk :
      sel_w0 ? rd_line[31:0] : sel_w1 ? rd_line[63:32] :
      sel_w2 ? rd_line[95:64] : sel_w3 ? rd_line[127:96] :
      sel_lru ? lru_val : sel_hit ? hit_cnt_r :
      sel_mis ? mis_cnt_r : sel_abt ? abt_cnt_r : 32'h0000_0000;

  assign sw.wdata   = newv;
  assign sw.tag_we  = reg_wr_i & sel_tag & line_wen;
  assign sw.msk_we  = reg_wr_i & sel_msk & line_wen;
  assign sw.word_we = {sel_w3, sel_w2, sel_w1, sel_w0} & {4{reg_wr_i & line_wen}};
  assign sw.idx     = acc_r[`FPC_IDX_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Fetch path control
  wire logic [2:0] dlines = (ctrl_r[9:8] == 2'h3) ? 3'h4 : (ctrl_r[9:8] == 2'h2) ? 3'h2 :
                            (ctrl_r[9:8] == 2'h1) ? 3'h1 : 3'h0; // RULE_02
  wire logic st_idle    = (state_r == fpc_pkg::ST_IDLE);
  wire logic st_fill    = (state_r == fpc_pkg::ST_FILL);
  wire logic st_pref    = (state_r == fpc_pkg::ST_PREF);
  wire logic take       = fetch_req_i & !ack_r & (st_idle | st_pref);
  wire logic serve      = take & hit;
  wire logic abort      = take & !hit & st_pref;
  wire logic start_dem  = take & !hit & st_idle;
  wire logic start_pref = st_idle & !take & pref_pend_r;
  wire logic pref_ok    = req_r.cacheable ? ctrl_r[4] : ctrl_r[5]; // RULE_04
  wire logic fill_allow = req_r.cacheable & (!req_r.is_data | (dlines != 3'h0)); // RULE_02
  wire logic to_dline   = st_fill & req_r.is_data;
  wire fpc_pkg::fpc_idx_t victim = to_dline ? {2'h0, d_ptr_r} :
                                   fpc_pkg::fpc_idx_t'(`FPC_DATA_LINES) + i_ptr_r;
  // A locked victim is simply not refilled; the search for a free line is left out
  wire logic fill_we = t_done & ((st_fill & fill_allow) | st_pref) & !lock_vec[victim];

  assign fill.we   = fill_we;
  assign fill.idx  = victim;
  assign fill.kind = !to_dline;
  assign fill.tag  = {flash_addr_r[`FPC_BOOT_ADDR_BIT], flash_addr_r[30:0]};
  assign fill.line = flash_line_i;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      fpc_pkg::ST_IDLE:
        if (start_dem)
          state_nxt = fpc_pkg::ST_FILL;
        else if (start_pref)
          state_nxt = fpc_pkg::ST_PREF;
      fpc_pkg::ST_FILL:
        if (t_done)
          state_nxt = fpc_pkg::ST_IDLE;
      fpc_pkg::ST_PREF:
        if (abort | t_done)
          state_nxt = fpc_pkg::ST_IDLE;
      default:
        state_nxt = fpc_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r  <= `FPC_CTRL_RST; // RULE_05
      acc_r   <= 32'h0000_0000;
      state_r <= fpc_pkg::ST_IDLE;
      rdata_r <= 32'h0000_0000;
      ack_r   <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_r <= ctrl_nxt;
      if (reg_wr_i & sel_acc)
        acc_r <= newv & `FPC_ACC_MASK;
      state_r <= state_nxt;
      rdata_r <= reg_rd_i ? rd_val : 32'h0000_0000;
      ack_r   <= serve | (st_fill & t_done);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pref_pend_r  <= 1'b0;
      d_ptr_r      <= 2'h0;
      i_ptr_r      <= '0;
      flash_addr_r <= 32'h0000_0000;
      fdata_r      <= 32'h0000_0000;
      req_r        <= '0;
      pref_addr_r  <= 32'h0000_0000;
    end
    else
    begin
      if (start_dem)
      begin
        req_r        <= fetch_i;
        flash_addr_r <= {fetch_i.addr[31:4], 4'h0};
      end
      else if (start_pref)
        flash_addr_r <= pref_addr_r;
      if (serve)
        fdata_r <= hit_word;
      else if (st_fill & t_done)
        fdata_r <= flash_line_i[{req_r.addr[3:2], 5'h00} +: 32];
      if (st_fill & t_done)
      begin
        pref_pend_r <= pref_ok; // RULE_04
        pref_addr_r <= flash_addr_r + `FPC_LINE_BYTES;
      end
      else if (start_pref | start_dem)
        pref_pend_r <= 1'b0;
      if (inv_all)
        d_ptr_r <= 2'h0;
      else if (fill_we & to_dline)
        d_ptr_r <= ({1'b0, d_ptr_r} + 3'h1 >= dlines) ? 2'h0 : d_ptr_r + 2'h1;
      if (fill_we & !to_dline)
        i_ptr_r <= (int'(i_ptr_r) + 1 >= ILINES) ? '0 : i_ptr_r + 1'b1;
    end
  end

  // Counters are left unreset on purpose; software seeds them
  always_ff @(posedge clk_sys_i)
  begin
    hit_cnt_r <= (reg_wr_i & sel_hit) ? reg_wdata_i : hit_cnt_r + {31'h0, serve}; // RULE_08
    mis_cnt_r <= (reg_wr_i & sel_mis) ? reg_wdata_i : mis_cnt_r + {31'h0, start_dem};
    abt_cnt_r <= (reg_wr_i & sel_abt) ? reg_wdata_i : abt_cnt_r + {31'h0, abort};
  end

  assign reg_rdata_o   = rdata_r;
  assign fetch_ack_o   = ack_r;
  assign fetch_rdata_o = fdata_r;
  assign flash_req_o   = t_busy;
  assign flash_addr_o  = flash_addr_r;

  ////////////////////////////////////////////////////////////////////////////
  fpc_line_store #(
    .NUM_LINES      (NUM_LINES)
  ) u_store (
    .clk_sys_i      (clk_sys_i),
    .rst_n_i        (rst_n_i),
    .inv_all_i      (inv_all),
    .inv_unlocked_i (inv_unl),
    .lk_i           (fetch_i),
    .data_lines_i   (dlines),
    .hit_o          (hit),
    .hit_word_o     (hit_word),
    .sw_i           (sw),
    .fill_i         (fill),
    .rd_tag_o       (rd_tag),
    .rd_msk_o       (rd_msk),
    .rd_line_o      (rd_line),
    .valid_o        (valid_vec),
    .lock_o         (lock_vec)
  );

  fpc_wait_timer #(
    .WS_W      (3)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (start_dem | start_pref),
    .abort_i   (abort),
    .wait_i    (ctrl_r[2:0]), // RULE_05
    .busy_o    (t_busy),
    .done_o    (t_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_data_line_count_inval;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $changed(ctrl_r[9:8]) |-> (valid_vec == '0);
  endproperty
  a_data_line_count_inval: assert property (p_data_line_count_inval) // RULE_03
    else $error("line valid after data line count change");

  property p_set_alias;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_wr_i & sel_ctrl & (op == `FPC_OP_SET)) |=>
      (ctrl_r == ($past(ctrl_r) | ($past(reg_wdata_i) & `FPC_CTRL_MASK)));
  endproperty
  a_set_alias: assert property (p_set_alias) // RULE_06
    else $error("set alias did not set control bits");

  property p_clr_alias;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_wr_i & sel_acc & (op == `FPC_OP_CLR)) |=>
      (acc_r == ($past(acc_r) & ~$past(reg_wdata_i)));
  endproperty
  a_clr_alias: assert property (p_clr_alias) // RULE_09
    else $error("clear alias changed bits written zero");

  property p_unimpl_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rd_i ##1 (reg_rdata_o != 32'h0000_0000) |->
      ($past(mapped) & ((reg_rdata_o & ~`FPC_CTRL_MASK) == '0 || !$past(sel_ctrl)));
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // RULE_07
    else $error("unmapped or unimplemented bits read nonzero");

  property p_pref_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (st_fill & t_done & (ctrl_r[5:4] == 2'h0)) |=> !pref_pend_r ##1 !st_pref;
  endproperty
  a_pref_off: assert property (p_pref_off) // RULE_04
    else $error("prefetch started while disabled");

  property p_dline_range;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (fill_we & to_dline) |-> ({1'b0, victim} < {2'h0, dlines});
  endproperty
  a_dline_range: assert property (p_dline_range) // RULE_02
    else $error("data line filled outside configured count");

  c_hit:   cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) serve);
  c_abort: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) abort);
  c_inv:   cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                           reg_wr_i & sel_ctrl & (op == `FPC_OP_INV));

endmodule : fpc_top

// >>> test/fpc_flash_model.sv
// Flash array model answering line reads of the cache
`timescale 1ns/1ns
module fpc_flash_model (
  // Clock
  input  wire logic         clk_sys_i,
  // Flash access
  input  wire logic         flash_req_i,
  input  wire logic [31:0]  flash_addr_i,
  output logic [127:0]      flash_line_o
);
  logic [31:0] noise_r = 32'h1357_9BDF;
  logic        hold_r  = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Data held one cycle past the request, then noise so stale lines never match
  always_ff @(posedge clk_sys_i)
  begin
    noise_r <= noise_r + 32'h0000_9E37;
    hold_r  <= flash_req_i;
  end
  assign flash_line_o = (flash_req_i | hold_r) ? ({flash_addr_i | 32'hC, flash_addr_i | 32'h8,
    flash_addr_i | 32'h4, flash_addr_i} ^ {4{32'h5A5A_A5A5}}) : {4{noise_r}};
endmodule : fpc_flash_model

// >>> test/tb.sv
// Self-checking bench of the flash prefetch cache control
`timescale 1ns/1ns
module tb;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0, prog = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata, frd, faddr, lf = 32'd74153, d, e;
  logic [127:0] line;
  logic ack, freq;
  fpc_pkg::fpc_fetch_t fs = '0;
  int n_fail = 0, checked = 0, cyc = 0, ws = 7;
  always #5 clk_sys_i = ~clk_sys_i;
  fpc_top fpc_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .fetch_req_i(req), .fetch_i(fs), .fetch_ack_o(ack), .fetch_rdata_o(frd),
    .flash_req_o(freq), .flash_addr_o(faddr), .flash_line_i(line),
    .flash_prog_cycle_i(prog));
  fpc_flash_model fpc_flash_model_inst (.clk_sys_i(clk_sys_i), .flash_req_i(freq),
    .flash_addr_i(faddr), .flash_line_o(line));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  task automatic end_sim();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wreg(input logic [15:0] a, input logic [31:0] v);
    if (a == 16'h4000)
      ws = int'(v[2:0]);
    @(posedge clk_sys_i);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [15:0] a, input logic [31:0] x);
    @(posedge clk_sys_i);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(posedge clk_sys_i);
    chk(rdata, x);
  endtask : rreg
  // Latency counted from the taking edge to the edge that sees the answer
  task automatic fetch(input logic [31:0] a, input logic dt, c, input int lat);
    int n;
    int nb;
    logic [31:0] fa;
    @(posedge clk_sys_i);
    req <= 1'b1; fs <= '{addr: a, is_data: dt, cacheable: c};
    n = 0;
    nb = 0;
    fa = 32'h0000_0000;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      // The taking edge may still show a prefetch that this request cuts short
      if (n > 1 && freq === 1'b1)
      begin
        nb++;
        fa = faddr;
      end
    end while (ack !== 1'b1 && n < 60);
    req <= 1'b0;
    chk(32'(n - 1), 32'(lat));
    chk(frd, (a & 32'hFFFF_FFFC) ^ 32'h5A5A_A5A5);
    chk(32'(nb), (lat == 1) ? 32'h0000_0000 : 32'(ws + 1));
    chk(fa, (lat == 1) ? 32'h0000_0000 : (a & 32'hFFFF_FFF0));
  endtask : fetch
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rreg(16'h4000, 32'h0000_0007);
    wreg(16'h4000, 32'hFFFF_FFFF);
    rreg(16'h4000, 32'h0001_0337);
    rreg(16'h40B0, 32'h0000_0000);
    rreg(16'h4004, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      e = rnd() & 32'h0001_0337;
      wreg(16'h4000, e);
      d = rnd(); wreg(16'h4004, d); e = e & ~d;
      d = rnd(); wreg(16'h4008, d); e = (e | d) & 32'h0001_0337;
      d = rnd(); wreg(16'h400C, d); e = (e ^ d) & 32'h0001_0337;
      rreg(16'h4000, e);
    end
    for (int w = 0; w < 8; w++)
    begin
      wreg(16'h4000, 32'(w));
      d = (rnd() & 32'h000F_FFF0) | 32'(w << 20);
      fetch(d, 1'b0, 1'b1, w + 3);
      fetch(d | 32'h8, 1'b0, 1'b1, 1);
    end
    for (int c = 0; c < 2; c++)
    begin
      wreg(16'h4000, 32'(c << 16) | 32'h2);
      d = 32'h0090_0000 | 32'(c << 8);
      fetch(d, 1'b0, 1'b1, 5);
      // Locked instruction line loaded by hand: only a full invalidation drops it
      wreg(16'h4010, 32'h8000_000F);
      wreg(16'h4030, 32'h0000_0000);
      wreg(16'h4020, 32'h00C0_001E);
      wreg(16'h4050, 32'h00C0_0014 ^ 32'h5A5A_A5A5);
      rreg(16'h4020, 32'h00C0_001E);
      @(posedge clk_sys_i) prog <= 1'b1;
      @(posedge clk_sys_i) prog <= 1'b0;
      fetch(d, 1'b0, 1'b1, 5);
      fetch(32'h00C0_0014, 1'b0, 1'b1, (c == 0) ? 1 : 5);
      wreg(16'h4020, 32'h0000_0000);
    end
    for (int k = 0; k < 4; k++)
    begin
      d = 32'h00A0_0000 | 32'(k << 8);
      fetch(d, 1'b0, 1'b1, 5);
      wreg(16'h4000, 32'(k << 8) | 32'h2);
      fetch(d, 1'b0, 1'b1, (k == 0) ? 1 : 5);
      fetch(d | 32'h4, 1'b1, 1'b1, 5);
      fetch(d | 32'h4, 1'b1, 1'b1, (k == 0) ? 5 : 1);
    end
    for (int p = 0; p < 8; p++)
    begin
      wreg(16'h4000, 32'((p & 3) << 4) | 32'h1);
      d = 32'h00B0_0000 | 32'(p << 8);
      fetch(d, 1'b0, p[2], 4);
      repeat (12) @(posedge clk_sys_i);
      fetch(d + 32'h10, 1'b0, p[2], (p[p[2] ? 0 : 1]) ? 1 : 4);
    end
    // A miss during a running prefetch aborts it and is taken again a cycle later
    wreg(16'h40C0, 32'h0000_0000);
    fetch(32'h00B0_0800, 1'b0, 1'b1, 4);
    fetch(32'h00D0_0000, 1'b0, 1'b1, 5);
    rreg(16'h40C0, 32'h0000_0001);
    end_sim();
  end
endmodule : tb
